// ---- mmb_bus_ctrl.v ----
// Minimum-mode local bus controller with the instruction prefetch queue.
// Assumes synchronous hold, ready and execution unit inputs on i_clk.
`timescale 1ns/1ps
`include "mmb_defines.vh"

module mmb_bus_ctrl #(
   parameter DEPTH = `MMB_QUEUE_DEPTH,
   parameter CW = 3
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_hold,
   input wire i_ready,
   input wire [15:0] i_ad_in,
   input wire i_op_req,
   input wire i_op_write,
   input wire i_op_io,
   input wire i_op_int_ack_strobe_n,
   input wire [15:0] i_op_seg,
   input wire [15:0] i_op_off,
   input wire [15:0] i_op_wdata,
   input wire [15:0] i_code_seg,
   input wire i_flush,
   input wire [15:0] i_flush_ip,
   input wire i_q_take,
   output reg [15:0] o_ad_out,
   output reg o_ad_oe,
   output reg [3:0] o_addr_hi,
   output reg o_addr_hi_oe,
   output reg o_ale,
   output reg o_mio,
   output reg o_wr_n,
   output reg o_rd_n,
   output reg o_int_ack_strobe_n,
   output reg o_transmit_receive_dir,
   output reg o_transceiver_enable_n,
   output reg o_ctl_oe,
   output reg o_bus_release_grant,
   output reg o_op_done,
   output reg [15:0] o_op_rdata,
   output wire [7:0] o_q_byte,
   output wire o_q_valid
);

localparam ST_IDLE = `MMB_ST_IDLE;
localparam ST_T1 = `MMB_ST_T1;
localparam ST_T2 = `MMB_ST_T2;
localparam ST_T3 = `MMB_ST_T3;
localparam ST_TW = `MMB_ST_TW;
localparam ST_T4 = `MMB_ST_T4;
localparam ST_HOLD = `MMB_ST_HOLD;
// The fetch threshold is cut to the count width on purpose; it is small.
localparam integer ROOM_INT = DEPTH - `MMB_FETCH_ROOM;
localparam [CW-1:0] ROOM_LIMIT = ROOM_INT[CW-1:0];

////////////////////////////////////////////////////////////////////////////
// State. Each T-state lasts two clocks, so phase 0 is its first half and
// phase 1 its second; the phase bit is the divider's one-cycle enable.
reg [2:0] state_reg, state_next;
reg phase_reg, phase_next;
reg [1:0] cyc_reg, cyc_next;
reg start_reg, start_next;
reg [19:0] addr_reg, addr_next;
reg [15:0] wdata_reg, wdata_next;
reg [15:0] fetch_ip_reg, fetch_ip_next;
reg odd_reg, odd_next;
reg discard_reg, discard_next;
reg bus_release_grant_reg, bus_release_grant_next;
reg drive_reg, drive_next;
reg mio_reg, mio_next;
reg dir_reg, dir_next;
reg done_next;
reg [15:0] rdata_next;
reg [1:0] push_cnt;

reg [15:0] ad_out_next;
reg ad_oe_next;
reg ale_next;
reg wr_n_next;
reg rd_n_next;
reg int_ack_strobe_n_n_next;
reg den_n_next;
reg in_strobe;
reg den_on;

wire [CW-1:0] q_count;
wire op_want;
wire fetch_want;
wire edge_mid;
wire edge_end;

////////////////////////////////////////////////////////////////////////////
// Queue. A flush in the same clock as a push drops the pushed bytes.
mmb_queue #(
   .DEPTH(DEPTH),
   .CW(CW)
) u_queue (
   .i_clk(i_clk),
   .i_rst_n(i_rst_n),
   .i_flush(i_flush),
   .i_push_cnt(push_cnt),
   .i_push_data(i_ad_in),
   .i_pop(i_q_take),
   .o_head(o_q_byte),
   .o_valid(o_q_valid),
   .o_count(q_count)
);

// The done pulse blocks a second pick on the same request; the execution
// unit must drop its request in the clock after it sees the pulse.
assign op_want = i_op_req && !o_op_done;
assign fetch_want = (q_count <= ROOM_LIMIT);
assign edge_mid = !phase_reg;
assign edge_end = phase_reg;

////////////////////////////////////////////////////////////////////////////
// Sequencer.
always @* begin
   state_next = state_reg;
   phase_next = ~phase_reg;
   cyc_next = cyc_reg;
   start_next = start_reg;
   addr_next = addr_reg;
   wdata_next = wdata_reg;
   fetch_ip_next = fetch_ip_reg;
   odd_next = odd_reg;
   discard_next = discard_reg;
   bus_release_grant_next = bus_release_grant_reg;
   drive_next = drive_reg;
   mio_next = mio_reg;
   dir_next = dir_reg;
   done_next = 1'b0;
   rdata_next = o_op_rdata;
   push_cnt = `MMB_PUSH_NONE;
   case (state_reg)
      ST_IDLE, ST_T4: begin
         if (edge_mid) begin
            // Hold is seen only in mid-T4 or mid-idle, so a cycle never splits.
            if (i_hold) begin
               state_next = ST_HOLD;
               phase_next = 1'b0;
               bus_release_grant_next = 1'b1;
               drive_next = 1'b0;
            end else if (op_want) begin
               start_next = 1'b1;
               drive_next = 1'b1;
               cyc_next = i_op_int_ack_strobe_n ? `MMB_CY_INT_ACK_STROBE_N :
                  (i_op_write ? `MMB_CY_WRITE : `MMB_CY_READ);
               addr_next = {i_op_seg, `MMB_SEG_SHIFT} +
                  {4'h0, i_op_off};
               wdata_next = i_op_wdata;
               mio_next = !(i_op_io || i_op_int_ack_strobe_n);
               dir_next = i_op_write && !i_op_int_ack_strobe_n;
            end else if (fetch_want) begin
               start_next = 1'b1;
               drive_next = 1'b1;
               cyc_next = `MMB_CY_FETCH;
               addr_next = {i_code_seg, `MMB_SEG_SHIFT} +
                  {4'h0, fetch_ip_reg};
               odd_next = fetch_ip_reg[0];
               discard_next = 1'b0;
               mio_next = 1'b1;
               dir_next = 1'b0;
            end
         end else if (start_reg) begin
            state_next = ST_T1;
            start_next = 1'b0;
         end else begin
            state_next = ST_IDLE;
         end
      end
      ST_T1: begin
         if (edge_end) begin
            state_next = ST_T2;
         end
      end
      ST_T2: begin
         if (edge_end) begin
            state_next = ST_T3;
         end
      end
      ST_T3, ST_TW: begin
         if (edge_end) begin
            if (!i_ready) begin
               state_next = ST_TW;
            end else begin
               state_next = ST_T4;
               if (cyc_reg == `MMB_CY_FETCH) begin
                  if (!discard_reg && !i_flush) begin
                     push_cnt = odd_reg ? `MMB_PUSH_ONE :
                        `MMB_PUSH_TWO;
                     fetch_ip_next = fetch_ip_reg +
                        (odd_reg ? 16'h0001 : 16'h0002);
                  end
               end else begin
                  done_next = 1'b1;
                  if (cyc_reg != `MMB_CY_WRITE) begin
                     rdata_next = i_ad_in;
                  end
               end
            end
         end
      end
      ST_HOLD: begin
         phase_next = 1'b0;
         if (!i_hold) begin
            state_next = ST_IDLE;
            bus_release_grant_next = 1'b0;
         end
      end
      default: begin
         state_next = ST_IDLE;
         phase_next = 1'b0;
      end
   endcase
   // A change of flow redirects fetching and spoils any fetch in flight.
   if (i_flush) begin
      fetch_ip_next = i_flush_ip;
      if (cyc_next == `MMB_CY_FETCH) begin
         discard_next = 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// Pin values for the coming clock, worked out from the next state so that
// every pin leaves a flip-flop without a gate behind it.
always @* begin
   in_strobe = (state_next == ST_T2) || (state_next == ST_T3) ||
      (state_next == ST_TW);
   ale_next = (state_next == ST_T1);
   ad_out_next = (state_next == ST_T1) ? addr_next[15:0] : wdata_next;
   ad_oe_next = drive_next && ((state_next == ST_T1) ||
      ((cyc_next == `MMB_CY_WRITE) && (in_strobe ||
      (state_next == ST_T4))));
   wr_n_next = !(in_strobe && (cyc_next == `MMB_CY_WRITE));
   rd_n_next = !(in_strobe && ((cyc_next == `MMB_CY_FETCH) ||
      (cyc_next == `MMB_CY_READ)));
   int_ack_strobe_n_n_next = !(in_strobe && (cyc_next == `MMB_CY_INT_ACK_STROBE_N));
   // Receive cycles open the transceiver half a state later than writes,
   // so the bus has turned around before the buffers drive toward the core.
   den_on = ((state_next == ST_T2) &&
      (phase_next || (cyc_next == `MMB_CY_WRITE))) ||
      (state_next == ST_T3) || (state_next == ST_TW) ||
      ((state_next == ST_T4) && !phase_next);
   den_n_next = !den_on;
end

////////////////////////////////////////////////////////////////////////////
// Registers. After reset the bus stays floated until the first cycle.
always @(posedge i_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      phase_reg <= 1'b0;
      cyc_reg <= `MMB_CY_FETCH;
      start_reg <= 1'b0;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      fetch_ip_reg <= 16'h0000;
      odd_reg <= 1'b0;
      discard_reg <= 1'b0;
      bus_release_grant_reg <= 1'b0;
      drive_reg <= 1'b0;
      mio_reg <= 1'b0;
      dir_reg <= 1'b0;
   end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cyc_reg <= cyc_next;
      start_reg <= start_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      fetch_ip_reg <= fetch_ip_next;
      odd_reg <= odd_next;
      discard_reg <= discard_next;
      bus_release_grant_reg <= bus_release_grant_next;
      drive_reg <= drive_next;
      mio_reg <= mio_next;
      dir_reg <= dir_next;
   end
end

always @(posedge i_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      o_ad_out <= 16'h0000;
      o_ad_oe <= 1'b0;
      o_addr_hi <= 4'h0;
      o_addr_hi_oe <= 1'b0;
      o_ale <= 1'b0;
      o_mio <= 1'b0;
      o_wr_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_int_ack_strobe_n <= 1'b1;
      o_transmit_receive_dir <= 1'b0;
      o_transceiver_enable_n <= 1'b1;
      o_ctl_oe <= 1'b0;
      o_bus_release_grant <= 1'b0;
      o_op_done <= 1'b0;
      o_op_rdata <= 16'h0000;
   end else begin
      o_ad_out <= ad_out_next;
      o_ad_oe <= ad_oe_next;
      o_addr_hi <= addr_next[19:16];
      o_addr_hi_oe <= drive_next;
      o_ale <= ale_next;
      o_mio <= mio_next;
      o_wr_n <= wr_n_next;
      o_rd_n <= rd_n_next;
      o_int_ack_strobe_n <= int_ack_strobe_n_n_next;
      o_transmit_receive_dir <= dir_next;
      o_transceiver_enable_n <= den_n_next;
      o_ctl_oe <= drive_next;
      o_bus_release_grant <= bus_release_grant_next;
      o_op_done <= done_next;
      o_op_rdata <= rdata_next;
   end
end

endmodule

// ---- mmb_defines.vh ----
// Shared constants of the minimum-mode bus control and prefetch queue.
// Assumes inclusion by bare name from the design files of this block.
`ifndef MMB_DEFINES_VH
`define MMB_DEFINES_VH

// Bus state machine codes, one state per T-state of the local bus.
`define MMB_ST_IDLE 3'h0
`define MMB_ST_T1 3'h1
`define MMB_ST_T2 3'h2
`define MMB_ST_T3 3'h3
`define MMB_ST_TW 3'h4
`define MMB_ST_T4 3'h5
`define MMB_ST_HOLD 3'h6

// Kinds of bus cycle.
`define MMB_CY_FETCH 2'h0
`define MMB_CY_READ 2'h1
`define MMB_CY_WRITE 2'h2
`define MMB_CY_INT_ACK_STROBE_N 2'h3

// Prefetch queue geometry and the free room that starts a fetch.
`define MMB_QUEUE_DEPTH 6
`define MMB_FETCH_ROOM 2

// Segment base shift used by address relocation.
`define MMB_SEG_SHIFT 4'h0

// Queue push counts.
`define MMB_PUSH_NONE 2'h0
`define MMB_PUSH_ONE 2'h1
`define MMB_PUSH_TWO 2'h2

`endif

// ---- mmb_queue.v ----
// Byte-wide first-in first-out instruction queue, held as a shift register.
// Assumes the caller never pushes more bytes than there is room for.
`timescale 1ns/1ps
`include "mmb_defines.vh"

module mmb_queue #(
   parameter DEPTH = `MMB_QUEUE_DEPTH,
   parameter CW = 3
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_flush,
   input wire [1:0] i_push_cnt,
   input wire [15:0] i_push_data,
   input wire i_pop,
   output wire [7:0] o_head,
   output wire o_valid,
   output wire [CW-1:0] o_count
);

reg [DEPTH*8-1:0] q_reg;
reg [DEPTH*8-1:0] q_next;
reg [CW-1:0] count_reg;
reg [CW-1:0] count_next;
reg [CW-1:0] base;
reg pop_ok;
reg valid_reg;

////////////////////////////////////////////////////////////////////////////
// A pop shifts every byte down, so the head always sits in the low byte and
// a byte pushed into an empty queue is visible at the very next edge.
always @* begin
   q_next = q_reg;
   count_next = count_reg;
   pop_ok = i_pop && (count_reg != {CW{1'b0}});
   base = count_reg;
   if (pop_ok) begin
      q_next = {8'h00, q_reg[DEPTH*8-1:8]};
      base = count_reg - {{(CW-1){1'b0}}, 1'b1};
   end
   if (i_push_cnt == `MMB_PUSH_ONE) begin
      q_next[base*8 +: 8] = i_push_data[15:8];
      count_next = base + {{(CW-1){1'b0}}, 1'b1};
   end else if (i_push_cnt == `MMB_PUSH_TWO) begin
      q_next[base*8 +: 16] = i_push_data;
      count_next = base + {{(CW-2){1'b0}}, 2'h2};
   end else begin
      count_next = base;
   end
   if (i_flush) begin
      count_next = {CW{1'b0}};
   end
end

always @(posedge i_clk or negedge i_rst_n) begin
   if (!i_rst_n) begin
      q_reg <= {(DEPTH*8){1'b0}};
      count_reg <= {CW{1'b0}};
      valid_reg <= 1'b0;
   end else begin
      q_reg <= q_next;
      count_reg <= count_next;
      valid_reg <= (count_next != {CW{1'b0}});
   end
end

assign o_head = q_reg[7:0];
assign o_valid = valid_reg;
assign o_count = count_reg;

endmodule

// ---- mmb_props.sv ----
// Checker for the minimum-mode bus controller, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
module mmb_props (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_hold,
   input wire o_ale,
   input wire o_mio,
   input wire o_wr_n,
   input wire o_rd_n,
   input wire o_int_ack_strobe_n,
   input wire o_transmit_receive_dir,
   input wire o_transceiver_enable_n,
   input wire o_ctl_oe,
   input wire o_ad_oe,
   input wire o_addr_hi_oe,
   input wire o_bus_release_grant
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_t1;
      $rose(o_ale) ##1 o_ale;
   endsequence
   AST_ALE_T1: assert property (s_t1 |=> !o_ale)
      else $error("address latch pulse not two clocks");
   AST_SEL_STABLE: assert property (s_t1 |=> ($stable(o_mio) &&
      $stable(o_transmit_receive_dir))[*5])
      else $error("select or direction moved inside a cycle");
   AST_WR_STROBE: assert property (!o_wr_n |-> o_ctl_oe &&
      o_transmit_receive_dir && !o_transceiver_enable_n)
      else $error("write strobe without transmit and enable");
   AST_INT_ACK_STROBE_N_STROBE: assert property (!o_int_ack_strobe_n |->
      o_ctl_oe && !o_mio && !o_transmit_receive_dir)
      else $error("acknowledge strobe in wrong cycle kind");
   AST_DEN_READ: assert property (($fell(o_rd_n) ||
      $fell(o_int_ack_strobe_n)) |-> o_transceiver_enable_n ##1
      !o_transceiver_enable_n)
      else $error("receive enable not from mid T2");
   AST_DEN_WRITE: assert property ($fell(o_wr_n) |->
      !o_transceiver_enable_n)
      else $error("transmit enable not from start of T2");
   AST_T1_FIRST: assert property ($fell(o_rd_n) |-> $past(o_ale, 2))
      else $error("read strobe not preceded by T1");
   AST_HOLD_FLOAT: assert property (o_bus_release_grant |-> !o_ctl_oe
      && !o_ad_oe && !o_addr_hi_oe && !o_ale)
      else $error("lines driven during hold grant");
   AST_GRANT_CAUSE: assert property ($rose(o_bus_release_grant) |->
      $past(i_hold))
      else $error("grant without request");
   AST_GRANT_DROP: assert property (o_bus_release_grant && !i_hold |->
      ##[1:2] !o_bus_release_grant)
      else $error("grant kept after request fell");
endmodule
bind mmb_bus_ctrl mmb_props i_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_hold(i_hold), .o_ale(o_ale), .o_mio(o_mio), .o_wr_n(o_wr_n),
   .o_rd_n(o_rd_n), .o_int_ack_strobe_n(o_int_ack_strobe_n),
   .o_transmit_receive_dir(o_transmit_receive_dir),
   .o_transceiver_enable_n(o_transceiver_enable_n), .o_ctl_oe(o_ctl_oe),
   .o_ad_oe(o_ad_oe), .o_addr_hi_oe(o_addr_hi_oe),
   .o_bus_release_grant(o_bus_release_grant));

// ---- mmb_mem_model.sv ----
// Memory and I/O model on the local bus; byte n holds the value n[7:0].
// Assumes the address is latched while the latch pulse is high.
`timescale 1ns/1ps
module mmb_mem_model (
   input wire i_clk,
   input wire i_ale,
   input wire [15:0] i_ad,
   input wire i_ad_oe,
   input wire i_rd_n,
   input wire i_wr_n,
   input wire i_int_ack_strobe_n_n,
   input wire [3:0] i_waits,
   output logic [15:0] o_data,
   output logic o_ready,
   output logic [15:0] o_wdata
);
   logic [15:0] addr_reg;
   logic [7:0] cnt_reg;
   logic strobe;
   logic [15:0] word;
   assign strobe = !i_rd_n || !i_wr_n || !i_int_ack_strobe_n_n;
   assign word = {addr_reg[7:0] | 8'h01, addr_reg[7:0] & 8'hFE};
   // Ready is withheld for the requested number of wait states.
   assign o_ready = strobe && (cnt_reg >= 8'h03 + 2 * i_waits);
   // A released bus shows inverted data so stale values never match.
   assign o_data = (strobe && cnt_reg >= 8'h02) ? word : ~word;
   always @(posedge i_clk) begin
      if (i_ale) begin
         addr_reg <= i_ad;
         cnt_reg <= 8'h00;
      end else if (strobe) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
      if (!i_wr_n && i_ad_oe) begin
         o_wdata <= i_ad;
      end
   end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the bus controller and prefetch queue.
// Assumes a 40 MHz clock and the memory model on the local bus.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t value mismatch", $time); end end
module tb_top;
   logic i_clk = 0, i_rst_n = 0, i_hold = 0, i_ready, i_op_req = 0;
   logic i_op_write = 0, i_op_io = 0, i_op_int_ack_strobe_n = 0, i_flush = 0;
   logic i_q_take = 0;
   logic [15:0] i_ad_in, i_op_off = 0, i_flush_ip = 0, o_ad_out;
   logic [15:0] o_op_rdata, m_wdata;
   logic [3:0] o_addr_hi, waits = 0;
   logic o_ad_oe, o_addr_hi_oe, o_ale, o_mio, o_wr_n, o_rd_n, o_int_ack_strobe_n_n;
   logic o_dir, o_den_n, o_ctl_oe, o_grant, o_op_done, o_q_valid;
   logic ale_mio, ale_dir;
   logic [19:0] ale_addr;
   logic [7:0] o_q_byte;
   integer err_total = 0, checks = 0, cyc = 0, c;
   always #12.5 i_clk = ~i_clk;
   mmb_bus_ctrl i_mmb_bus_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_hold(i_hold), .i_ready(i_ready), .i_ad_in(i_ad_in),
      .i_op_req(i_op_req), .i_op_write(i_op_write), .i_op_io(i_op_io),
      .i_op_int_ack_strobe_n(i_op_int_ack_strobe_n), .i_op_seg(16'hF010), .i_op_off(i_op_off),
      .i_op_wdata({~i_op_off[7:0], i_op_off[7:0]}), .i_code_seg(16'h0000),
      .i_flush(i_flush), .i_flush_ip(i_flush_ip), .i_q_take(i_q_take),
      .o_ad_out(o_ad_out), .o_ad_oe(o_ad_oe), .o_addr_hi(o_addr_hi),
      .o_addr_hi_oe(o_addr_hi_oe), .o_ale(o_ale), .o_mio(o_mio),
      .o_wr_n(o_wr_n), .o_rd_n(o_rd_n), .o_int_ack_strobe_n(o_int_ack_strobe_n_n),
      .o_transmit_receive_dir(o_dir), .o_transceiver_enable_n(o_den_n),
      .o_ctl_oe(o_ctl_oe), .o_bus_release_grant(o_grant),
      .o_op_done(o_op_done), .o_op_rdata(o_op_rdata), .o_q_byte(o_q_byte),
      .o_q_valid(o_q_valid));
   mmb_mem_model i_mmb_mem_model (.i_clk(i_clk), .i_ale(o_ale),
      .i_ad(o_ad_out), .i_ad_oe(o_ad_oe), .i_rd_n(o_rd_n), .i_wr_n(o_wr_n),
      .i_int_ack_strobe_n_n(o_int_ack_strobe_n_n), .i_waits(waits), .o_data(i_ad_in),
      .o_ready(i_ready), .o_wdata(m_wdata));
   always @(posedge i_clk) begin
      if (o_ale) begin
         ale_mio <= o_mio;
         ale_dir <= o_dir;
         ale_addr <= {o_addr_hi, o_ad_out};
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task results;
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         results;
      end
   end
   task t_pop(input logic [7:0] v, input integer k);
      integer i, n;
      for (i = 0; i < k; i++) begin
         n = 0;
         do begin @(negedge i_clk); n++; end
         while (o_q_valid !== 1'b1 && n < 100);
         `CHK(o_q_valid, 1'b1)
         `CHK(o_q_byte, v + i[7:0])
         @(posedge i_clk) i_q_take <= 1;
         @(posedge i_clk) i_q_take <= 0;
      end
   endtask
   // Counts clocks with the latch pulse high over a fixed window.
   task t_ales(output integer n);
      n = 0;
      repeat (40) begin @(negedge i_clk); if (o_ale === 1'b1) n++; end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_fill;
      t_pop(8'h00, 6);
      repeat (200) @(posedge i_clk);
      t_ales(c);
      `CHK(c, 0)
      t_pop(8'h06, 1);
      t_ales(c);
      `CHK(c, 0)
      t_pop(8'h07, 1);
      t_ales(c);
      `CHK(c > 0, 1'b1)
   endtask
   task t_flush;
      @(posedge i_clk) begin i_flush <= 1; i_flush_ip <= 16'h0011; end
      @(posedge i_clk) i_flush <= 0;
      @(negedge i_clk);
      `CHK(o_q_valid, 1'b0)
      t_pop(8'h11, 3);
   endtask
   task t_op(input logic wr, io, ia, input logic [15:0] off,
         input logic [3:0] w);
      integer n;
      @(posedge i_clk) begin
         waits <= w; i_op_write <= wr; i_op_io <= io; i_op_int_ack_strobe_n <= ia;
         i_op_off <= off; i_op_req <= 1;
      end
      n = 0;
      do begin @(negedge i_clk); n++; end
      while (o_op_done !== 1'b1 && n < 200);
      `CHK(o_op_done, 1'b1)
      `CHK(ale_mio, !(io | ia))
      `CHK(ale_dir, wr)
      `CHK(ale_addr, {16'hF010, 4'h0} + {4'h0, off})
      if (wr)
         `CHK(m_wdata, {~off[7:0], off[7:0]})
      else
         `CHK(o_op_rdata, {off[7:0] | 8'h01, off[7:0] & 8'hFE})
      @(posedge i_clk) i_op_req <= 0;
   endtask
   task t_ops;
      t_op(0, 0, 0, 16'h0120, 0);
      t_op(1, 0, 0, 16'h0124, 2);
      t_op(0, 1, 0, 16'h0042, 1);
      t_op(1, 1, 0, 16'h0046, 0);
      t_op(0, 0, 1, 16'h0000, 0);
   endtask
   task t_hold;
      integer n;
      @(posedge i_clk) i_hold <= 1;
      n = 0;
      do begin @(negedge i_clk); n++; end
      while (o_grant !== 1'b1 && n < 40);
      `CHK(o_grant, 1'b1)
      `CHK(o_ctl_oe, 1'b0)
      `CHK(o_ale, 1'b0)
      t_ales(c);
      `CHK(c, 0)
      @(posedge i_clk) i_hold <= 0;
      repeat (2) @(negedge i_clk);
      `CHK(o_grant, 1'b0)
   endtask
   initial begin
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1;
      t_fill;
      t_flush;
      t_ops;
      t_hold;
      repeat (20) @(posedge i_clk);
      results;
   end
endmodule
